// >>> bench/cim_host.sv
/*
 * host model: serial register master with open-drain pull-up resolution.
 * assumes the bench clock; bus phases are five or ten clocks, well above the design's three-stage synchronizer.
 */
module cim_host
	import cim_pkg::*;
(
	// clock
	input  wire logic clk,
	// bus pins
	input  wire logic sda_oe,
	output logic      scl,
	output logic      sda
);
	timeunit 1ns;
	timeprecision 1ns;
	logic pull_low = 1'b0;
	initial scl = 1'b1;
	// released line floats to the pull-up
	assign sda = ~(pull_low | sda_oe);

	// ****************************************
	// bit and byte tasks
	// ****************************************
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick
	task automatic put(input logic b);
		pull_low = ~b;
		tick(5);
		scl = 1'b1;
		tick(10);
		scl = 1'b0;
		tick(5);
	endtask : put
	task automatic get(output logic b);
		pull_low = 1'b0;
		tick(5);
		scl = 1'b1;
		tick(5);
		b = sda;
		tick(5);
		scl = 1'b0;
		tick(5);
	endtask : get
	task automatic edge_pair(input logic first);
		pull_low = first;
		tick(5);
		scl = 1'b1;
		tick(10);
		pull_low = ~first;
		tick(10);
	endtask : edge_pair
	task automatic wbyte(input logic [7:0] d, inout logic nak);
		logic a;
		for (int i = 7; i >= 0; i--) put(d[i]);
		get(a);
		nak = nak | a;
	endtask : wbyte
	task automatic xfer(input logic [6:0] dev, input logic [7:0] ptr, input logic rd,
			inout logic [7:0] d, output logic nak);
		nak = 1'b0;
		edge_pair(1'b0);
		scl = 1'b0;
		tick(5);
		wbyte({dev, 1'b0}, nak);
		wbyte(ptr, nak);
		if (rd) begin
			edge_pair(1'b0);
			scl = 1'b0;
			tick(5);
			wbyte({dev, 1'b1}, nak);
			for (int i = 7; i >= 0; i--) get(d[i]);
			put(1'b1);
		end else begin
			wbyte(d, nak);
		end
		edge_pair(1'b1);
	endtask : xfer
	// two-byte read: the ack after byte one makes the device load the next
	task automatic rd_pair(input logic [6:0] dev, input logic [7:0] ptr,
			output logic [15:0] d, output logic nak);
		nak = 1'b0;
		edge_pair(1'b0);
		scl = 1'b0;
		tick(5);
		wbyte({dev, 1'b0}, nak);
		wbyte(ptr, nak);
		edge_pair(1'b0);
		scl = 1'b0;
		tick(5);
		wbyte({dev, 1'b1}, nak);
		for (int i = 15; i >= 8; i--) get(d[i]);
		put(1'b0);
		for (int i = 7; i >= 0; i--) get(d[i]);
		put(1'b1);
		edge_pair(1'b1);
	endtask : rd_pair
endmodule : cim_host

// >>> bench/cim_sva.sv
/*
 * port checker for cim_top, bound below.
 * assumes one clk domain and an active-low asynchronous rst_n.
 */
module cim_sva
	import cim_pkg::*;
#(
	parameter int BOOST_HOLD_CYCLES = BOOST_FAIL_CYCLES
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// design ports
	input  wire cim_events_t events,
	input  wire cim_power_t  power,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	input  wire logic        sda_out,
	input  wire logic        sda_oe,
	input  wire logic        int_n
);
	// ****************************************
	// properties
	// ****************************************
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// flag must hold until a read, so int_n stays low for a while
	property p_ovc;
		power.battery_switch_overcurrent |-> ##2 !int_n [*4];
	endproperty
	a_ovc: assert property (p_ovc) else $error("overcurrent did not pull int_n low");
	property p_safety;
		power.safety_timer_mode && power.fast_charge_expired |-> ##2 !int_n;
	endproperty
	a_safety: assert property (p_safety) else $error("safety timer expiry missed");
	property p_wdt_boost;
		!power.safety_timer_mode && power.watchdog_expired && power.boost_active |-> ##2 !int_n;
	endproperty
	a_wdt_boost: assert property (p_wdt_boost) else $error("watchdog in boost missed");
	property p_wdt_charge;
		!power.safety_timer_mode && power.watchdog_expired && power.charge_active |-> ##2 !int_n;
	endproperty
	a_wdt_charge: assert property (p_wdt_charge) else $error("watchdog in charge missed");
	property p_flags2;
		(|events.flags_2) |-> ##2 !int_n;
	endproperty
	a_flags2: assert property (p_flags2) else $error("unmasked flag gave no interrupt");
	property p_reset_int;
		$rose(rst_n) |-> int_n ##1 int_n;
	endproperty
	a_reset_int: assert property (p_reset_int) else $error("int_n low after reset");
	property p_reset_oe;
		$rose(rst_n) |-> !sda_oe;
	endproperty
	a_reset_oe: assert property (p_reset_oe) else $error("sda driven after reset");
	// data may only move while the serial clock is low
	property p_oe_scl;
		$changed(sda_oe) |-> !scl_in;
	endproperty
	a_oe_scl: assert property (p_oe_scl) else $error("sda changed with scl high");
	property p_od;
		sda_oe |-> !sda_out;
	endproperty
	a_od: assert property (p_od) else $error("sda driven high");

	c_int_fall: cover property ($fell(int_n));
	c_int_rise: cover property ($rose(int_n));
	c_ack: cover property ($rose(sda_oe));
endmodule : cim_sva

bind cim_top cim_sva #(.BOOST_HOLD_CYCLES(BOOST_HOLD_CYCLES)) sva_u (
	.clk(clk), .rst_n(rst_n), .events(events), .power(power), .scl_in(scl_in),
	.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .int_n(int_n)
);

// >>> bench/cim_top_test.sv
/*
 * self-checking bench for cim_top through its serial register port.
 * assumes cim_host as the far side and a shortened boost hold count.
 */
module cim_top_test
	import cim_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HOLD = 8;
	logic        clk    = 1'b0;
	logic        rst_n  = 1'b0;
	cim_events_t events = '0;
	cim_power_t  power  = '0;
	cim_events_t e;
	logic        scl, sda, sda_out, sda_oe, int_n, nak;
	logic [7:0]  rd, a, b, t;
	logic [15:0] w;
	logic [5:0]  tt [6] = '{6'h31, 6'h2C, 6'h0D, 6'h0B, 6'h08, 6'h10};
	int          fails    = 0;
	int          n_checks = 0;

	always #5 clk = ~clk;
	cim_top #(.BOOST_HOLD_CYCLES(HOLD)) dut_u (.clk(clk), .rst_n(rst_n), .events(events),
		.power(power), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.int_n(int_n));
	cim_host host_u (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));

	// ****************************************
	// tasks
	// ****************************************
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic results;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : results
	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		t = d;
		host_u.xfer(DEFAULT_DEVICE_ADDR, ad, 1'b0, t, nak);
	endtask : wr
	task automatic rdc(input string w, input logic [7:0] ad, input logic [7:0] exp);
		host_u.xfer(DEFAULT_DEVICE_ADDR, ad, 1'b1, rd, nak);
		check(w, rd, exp);
	endtask : rdc
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick

	// ****************************************
	// tests
	// ****************************************
	// hang guard sized at about 1.6 times the expected run
	initial begin
		#700000;
		fails++;
		results();
	end
	initial begin
		tick(12);
		rst_n = 1'b1;
		tick(4);
		check("int_n", {7'h00, int_n}, 8'h01);
		rdc("mask_0", ADDR_INTERRUPT_MASK_0, RESET_MASK);
		rdc("mask_1", ADDR_INTERRUPT_MASK_1, RESET_MASK);
		rdc("unmapped", 8'h20, READ_UNMAPPED);
		wr(ADDR_INTERRUPT_MASK_0, 8'hA5);
		rdc("mask_0", ADDR_INTERRUPT_MASK_0, 8'hA5);
		wr(8'h20, 8'h5A);
		check("ack", {7'h00, nak}, 8'h00);
		rdc("mask_1", ADDR_INTERRUPT_MASK_1, 8'h00);
		$display("test registers done");
		for (int i = 0; i < 13; i++) begin
			e = '0;
			if (i < 8) e.flags_0[i] = 1'b1;
			else e.flags_1[i - 5] = 1'b1;
			a = (i < 8) ? ADDR_INTERRUPT_MASK_0 : ADDR_INTERRUPT_MASK_1;
			b = 8'h01 << ((i < 8) ? i : i - 5);
			wr(a, b);
			events = e;
			tick(1);
			events = '0;
			tick(4);
			check("masked int_n", {7'h00, int_n}, 8'h01);
			wr(a, 8'h00);
			check("unmasked int_n", {7'h00, int_n}, 8'h00);
			rdc("flag", a - 8'h04, b);
			tick(4);
			check("cleared int_n", {7'h00, int_n}, 8'h01);
		end
		$display("test masks done");
		// all three groups at once, first two read back in one burst
		events = {8'h81, 8'h18, 8'h84};
		tick(1);
		events = '0;
		tick(4);
		check("event int_n", {7'h00, int_n}, 8'h00);
		host_u.rd_pair(DEFAULT_DEVICE_ADDR, ADDR_FLAGS_0, w, nak);
		check("pair flags_0", w[15:8], 8'h81);
		check("pair flags_1", w[7:0], 8'h18);
		check("flags_2 int_n", {7'h00, int_n}, 8'h00);
		rdc("flags_2", ADDR_FLAGS_2, 8'h84);
		tick(4);
		check("all read int_n", {7'h00, int_n}, 8'h01);
		$display("test burst read done");
		power.battery_switch_overcurrent = 1'b1;
		tick(1);
		power = '0;
		tick(4);
		check("ovc int_n", {7'h00, int_n}, 8'h00);
		rdc("ovc flag", ADDR_FLAGS_2, 8'h02);
		rdc("ovc cleared", ADDR_FLAGS_2, 8'h00);
		for (int k = 0; k < 6; k++) begin
			power = {tt[k][5:1], 3'b000};
			tick(1);
			power = '0;
			tick(4);
			rdc("timer", ADDR_FLAGS_2, {7'h00, tt[k][0]});
		end
		$display("test timer done");
		// exactly HOLD cycles must not fire, one more must
		for (int h = HOLD; h <= HOLD + 1; h++) begin
			power = 8'h13;
			tick(h);
			power = '0;
			tick(4);
			rdc("boost_fail", ADDR_FLAGS_1, (h > HOLD) ? 8'h08 : 8'h00);
		end
		t = 8'hFF;
		host_u.xfer(DEFAULT_DEVICE_ADDR ^ 7'h01, ADDR_INTERRUPT_MASK_0, 1'b0, t, nak);
		check("wrong addr nak", {7'h00, nak}, 8'h01);
		rdc("mask_0 kept", ADDR_INTERRUPT_MASK_0, 8'h00);
		$display("test boost and address done");
		results();
	end
endmodule : cim_top_test

// >>> pkg/cim_pkg.sv
/*
 * constants, register map and carrier types of the charger interrupt flag and mask logic.
 * assumes a single 100 MHz clock shared by the event sources and the serial register port.
 */
package cim_pkg;

	// ****************************************
	// clock and timing
	// ****************************************
	localparam int CLK_PERIOD_NS     = 10;
	localparam int BOOST_FAIL_TIME_NS = 50000;
	// least time, so round up
	localparam int BOOST_FAIL_CYCLES =
		(BOOST_FAIL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] ADDR_FLAGS_0         = 8'h04;
	localparam logic [7:0] ADDR_FLAGS_1         = 8'h05;
	localparam logic [7:0] ADDR_FLAGS_2         = 8'h06;
	localparam logic [7:0] ADDR_INTERRUPT_MASK_0 = 8'h08;
	localparam logic [7:0] ADDR_INTERRUPT_MASK_1 = 8'h09;
	localparam logic [7:0] RESET_FLAGS          = 8'h00;
	localparam logic [7:0] RESET_MASK           = 8'h00;
	localparam logic [7:0] READ_UNMAPPED        = 8'h00;

	// ****************************************
	// field positions
	// ****************************************
	localparam int BIT_TIMER                  = 0;
	localparam int BIT_BATTERY_SWITCH_OVERCURRENT = 1;
	localparam int BIT_BOOST_FAILURE          = 3;

	// device address on the serial port, value arbitrary
	localparam logic [6:0] DEFAULT_DEVICE_ADDR = 7'h2A;

	// ****************************************
	// carrier types
	// ****************************************
	typedef struct packed {
		logic [7:0] flags_0;
		logic [7:0] flags_1;
		logic [7:0] flags_2;
	} cim_events_t;

	typedef struct packed {
		logic safety_timer_mode;
		logic fast_charge_expired;
		logic watchdog_expired;
		logic boost_active;
		logic charge_active;
		logic battery_switch_overcurrent;
		logic boost_current_limit;
		logic boost_vout_low;
	} cim_power_t;

	typedef enum logic [3:0] {
		ST_IDLE     = 4'b0000,
		ST_ADDR     = 4'b0001,
		ST_ADDR_ACK = 4'b0010,
		ST_PTR      = 4'b0011,
		ST_PTR_ACK  = 4'b0100,
		ST_WDATA    = 4'b0101,
		ST_WDATA_ACK = 4'b0110,
		ST_RDATA    = 4'b0111,
		ST_RACK     = 4'b1000
	} cim_state_t;

endpackage : cim_pkg

// >>> rtl/cim_sustain.sv
/*
 * qualifier: one-cycle pulse when a condition has held for longer than HOLD_CYCLES.
 * assumes the condition is already in the clk domain.
 */
module cim_sustain
	import cim_pkg::*;
#(
	parameter int HOLD_CYCLES = BOOST_FAIL_CYCLES
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// condition and result
	input  wire logic cond,
	output logic      fire
);

	if (HOLD_CYCLES < 1) begin : g_check
		$error("cim_sustain: HOLD_CYCLES must be at least 1");
	end

	localparam int CW = $clog2(HOLD_CYCLES + 1) + 1;

	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic          next_fire;

	// ****************************************
	// hold counter
	// ****************************************
	always_comb begin
		next_count = count;
		next_fire  = 1'b0;
		if (!cond) begin
			next_count = '0;
		end else if (count < CW'(HOLD_CYCLES)) begin
			next_count = count + 1'b1;
		end else if (count == CW'(HOLD_CYCLES)) begin
			// strictly longer than the interval, fire once per episode
			next_count = count + 1'b1;
			next_fire  = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
			fire  <= 1'b0;
		end else begin
			count <= next_count;
			fire  <= next_fire;
		end
	end

endmodule : cim_sustain

// >>> rtl/cim_top.sv
/*
 * interrupt flag and mask logic of a battery charger with its serial register port.
 * assumes event inputs are on clk; serial clock and data pins are asynchronous.
 */
// Notes on behaviour
// - battery switch overcurrent sets flag bit 1
// - safety timer expiry sets timer flag bit 0
// - watchdog expiry in boost/charge sets timer flag, outside safety timer mode only
// - mask 0 bit 7 blocks valid-input failure
// - mask 0 bit 6 blocks secondary input change
// - mask 0 bit 5 blocks primary input change
// - mask 0 bit 4 blocks low battery threshold
// - mask 0 bit 3 blocks charge done
// - mask 0 bit 2 blocks charge phase change
// - mask 0 bit 1 blocks weak battery
// - mask 0 bit 0 blocks battery event
// - mask 1 bit 7 blocks charge current crossing
// - mask 1 bit 6 blocks recharge needed
// - mask 1 bit 5 blocks boost overvoltage
// - mask 1 bit 4 blocks boost thermal shutdown
// - mask 1 bit 3 blocks boost failure
// - boost failure is current limit with low output in boost beyond 50us
module cim_top
	import cim_pkg::*;
#(
	parameter int         BOOST_HOLD_CYCLES = BOOST_FAIL_CYCLES,
	parameter logic [6:0] DEVICE_ADDR       = DEFAULT_DEVICE_ADDR
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// event sources
	input  wire cim_events_t events,
	input  wire cim_power_t  power,
	// serial register port
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	// interrupt
	output logic             int_n
);

	if (BOOST_HOLD_CYCLES < 1) begin : g_check
		$error("cim_top: BOOST_HOLD_CYCLES must be at least 1");
	end

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [2:0] scl_sync;
	logic [2:0] sda_sync;
	logic [2:0] next_scl_sync;
	logic [2:0] next_sda_sync;

	always_comb begin
		next_scl_sync = {scl_sync[1:0], scl_in};
		next_sda_sync = {sda_sync[1:0], sda_in};
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_sync <= 3'h7;
			sda_sync <= 3'h7;
		end else begin
			scl_sync <= next_scl_sync;
			sda_sync <= next_sda_sync;
		end
	end

	// stage 0 feeds only stage 1; edges are seen between stages 1 and 2
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic sda_now;

	assign sda_now   = sda_sync[1];
	assign scl_rise  = scl_sync[1] & ~scl_sync[2];
	assign scl_fall  = ~scl_sync[1] & scl_sync[2];
	assign bus_start = scl_sync[1] & scl_sync[2] & ~sda_sync[1] & sda_sync[2];
	assign bus_stop  = scl_sync[1] & scl_sync[2] & sda_sync[1] & ~sda_sync[2];

	// ****************************************
	// event qualification
	// ****************************************
	logic boost_fail_pulse;

	cim_sustain #(
		.HOLD_CYCLES (BOOST_HOLD_CYCLES)
	) u_boost_fail (
		.clk   (clk),
		.rst_n (rst_n),
		.cond  (power.boost_active & power.boost_current_limit & power.boost_vout_low),
		.fire  (boost_fail_pulse)
	);

	logic timer_event;
	logic [7:0] set_0;
	logic [7:0] set_1;
	logic [7:0] set_2;

	always_comb begin
		// safety timer and watchdog share one flag
		timer_event = power.safety_timer_mode ? power.fast_charge_expired
			: (power.watchdog_expired & (power.boost_active | power.charge_active));
		set_0 = events.flags_0;
		set_1 = events.flags_1;
		set_1[BIT_BOOST_FAILURE] = events.flags_1[BIT_BOOST_FAILURE] | boost_fail_pulse;
		set_2 = events.flags_2;
		set_2[BIT_TIMER] = events.flags_2[BIT_TIMER] | timer_event;
		set_2[BIT_BATTERY_SWITCH_OVERCURRENT] = events.flags_2[BIT_BATTERY_SWITCH_OVERCURRENT]
			| power.battery_switch_overcurrent;
	end

	// ****************************************
	// serial port state machine
	// ****************************************
	cim_state_t state;
	cim_state_t next_state;
	logic [7:0] shift;
	logic [7:0] next_shift;
	logic [3:0] bit_count;
	logic [3:0] next_bit_count;
	logic [7:0] pointer;
	logic [7:0] next_pointer;
	logic       read_mode;
	logic       next_read_mode;
	logic       host_ack;
	logic       next_host_ack;
	logic       next_sda_oe;
	logic       wr_strobe;
	logic [7:0] wr_data;
	logic       rd_strobe;
	logic [7:0] rd_data;
	logic [7:0] flags_0;
	logic [7:0] flags_1;
	logic [7:0] flags_2;
	logic [7:0] interrupt_mask_0;
	logic [7:0] interrupt_mask_1;

	// read data mux
	always_comb begin
		case (pointer)
			ADDR_FLAGS_0:          rd_data = flags_0;
			ADDR_FLAGS_1:          rd_data = flags_1;
			ADDR_FLAGS_2:          rd_data = flags_2;
			ADDR_INTERRUPT_MASK_0: rd_data = interrupt_mask_0;
			ADDR_INTERRUPT_MASK_1: rd_data = interrupt_mask_1;
			default:               rd_data = READ_UNMAPPED;
		endcase
	end

	always_comb begin
		next_state     = state;
		next_shift     = shift;
		next_bit_count = bit_count;
		next_pointer   = pointer;
		next_read_mode = read_mode;
		next_host_ack  = host_ack;
		next_sda_oe    = sda_oe;
		wr_strobe      = 1'b0;
		wr_data        = shift;
		rd_strobe      = 1'b0;
		if (bus_stop) begin
			next_state  = ST_IDLE;
			next_sda_oe = 1'b0;
		end else if (bus_start) begin
			next_state     = ST_ADDR;
			next_bit_count = 4'h0;
			next_sda_oe    = 1'b0;
		end else begin
			case (state)
				ST_ADDR, ST_PTR, ST_WDATA: begin
					if (scl_rise && bit_count < 4'h8) begin
						next_shift     = {shift[6:0], sda_now};
						next_bit_count = bit_count + 4'h1;
					end else if (scl_fall && bit_count == 4'h8) begin
						next_bit_count = 4'h0;
						next_sda_oe    = 1'b1;
						if (state == ST_ADDR) begin
							next_read_mode = shift[0];
							next_state     = ST_ADDR_ACK;
							if (shift[7:1] != DEVICE_ADDR) begin
								// not ours: stay off the bus until the next start
								next_sda_oe = 1'b0;
								next_state  = ST_IDLE;
							end
						end else if (state == ST_PTR) begin
							next_pointer = shift;
							next_state   = ST_PTR_ACK;
						end else begin
							wr_strobe  = 1'b1;
							next_state = ST_WDATA_ACK;
						end
					end
				end
				ST_ADDR_ACK, ST_RACK: begin
					if (state == ST_RACK && scl_rise) begin
						next_host_ack = ~sda_now;
					end else if (scl_fall) begin
						if (read_mode && (state == ST_ADDR_ACK || host_ack)) begin
							// clear on load: a byte lost to a nack stays lost
							rd_strobe      = 1'b1;
							next_shift     = {rd_data[6:0], 1'b0};
							next_sda_oe    = ~rd_data[7];
							next_bit_count = 4'h1;
							next_pointer   = pointer + 8'h01;
							next_state     = ST_RDATA;
						end else begin
							next_sda_oe = 1'b0;
							next_state  = read_mode ? ST_IDLE : ST_PTR;
						end
					end
				end
				ST_PTR_ACK, ST_WDATA_ACK: begin
					if (scl_fall) begin
						next_sda_oe = 1'b0;
						next_state  = ST_WDATA;
					end
				end
				ST_RDATA: begin
					if (scl_fall) begin
						if (bit_count == 4'h8) begin
							next_sda_oe = 1'b0;
							next_state  = ST_RACK;
						end else begin
							next_sda_oe    = ~shift[7];
							next_shift     = {shift[6:0], 1'b0};
							next_bit_count = bit_count + 4'h1;
						end
					end
				end
				default: begin
					next_sda_oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state     <= ST_IDLE;
			shift     <= 8'h00;
			bit_count <= 4'h0;
			pointer   <= 8'h00;
			read_mode <= 1'b0;
			host_ack  <= 1'b0;
			sda_oe    <= 1'b0;
			sda_out   <= 1'b0;
		end else begin
			state     <= next_state;
			shift     <= next_shift;
			bit_count <= next_bit_count;
			pointer   <= next_pointer;
			read_mode <= next_read_mode;
			host_ack  <= next_host_ack;
			sda_oe    <= next_sda_oe;
			// open drain: the line is only ever pulled low
			sda_out   <= 1'b0;
		end
	end

	// ****************************************
	// flags, masks and interrupt
	// ****************************************
	logic [7:0] next_flags_0;
	logic [7:0] next_flags_1;
	logic [7:0] next_flags_2;
	logic [7:0] next_mask_0;
	logic [7:0] next_mask_1;
	logic [7:0] clr_0;
	logic [7:0] clr_1;
	logic [7:0] clr_2;
	logic [7:0] live_0;
	logic [7:0] live_1;
	logic       next_int_n;

	always_comb begin
		clr_0 = (rd_strobe && pointer == ADDR_FLAGS_0) ? 8'hFF : 8'h00;
		clr_1 = (rd_strobe && pointer == ADDR_FLAGS_1) ? 8'hFF : 8'h00;
		clr_2 = (rd_strobe && pointer == ADDR_FLAGS_2) ? 8'hFF : 8'h00;
		// a new event in the clearing cycle survives
		next_flags_0 = (flags_0 & ~clr_0) | set_0;
		next_flags_1 = (flags_1 & ~clr_1) | set_1;
		next_flags_2 = (flags_2 & ~clr_2) | set_2;
		next_mask_0  = interrupt_mask_0;
		next_mask_1  = interrupt_mask_1;
		if (wr_strobe && pointer == ADDR_INTERRUPT_MASK_0) begin
			next_mask_0 = wr_data;
		end
		if (wr_strobe && pointer == ADDR_INTERRUPT_MASK_1) begin
			next_mask_1 = wr_data;
		end
		// one gate per bit: mask 1 means blocked
		live_0 = flags_0 & ~interrupt_mask_0;
		live_1 = flags_1 & ~interrupt_mask_1;
		// third flag group has no mask here, so it always reaches the pin
		next_int_n = ~(|live_0 | |live_1 | |flags_2);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_0          <= RESET_FLAGS;
			flags_1          <= RESET_FLAGS;
			flags_2          <= RESET_FLAGS;
			interrupt_mask_0 <= RESET_MASK;
			interrupt_mask_1 <= RESET_MASK;
			int_n            <= 1'b1;
		end else begin
			flags_0          <= next_flags_0;
			flags_1          <= next_flags_1;
			flags_2          <= next_flags_2;
			interrupt_mask_0 <= next_mask_0;
			interrupt_mask_1 <= next_mask_1;
			int_n            <= next_int_n;
		end
	end

endmodule : cim_top
